// ===== rtl/pod_port_diag.sv
/*
 pod_port_diag: output image decode, pin-2 output supervision,
 switching-line retry, link mode override and diagnostic events.
 Assumes pin inputs are asynchronous and the diagnostic sink
 accepts one event per cycle without back-pressure.
*/
// Contract
// - image byte 1 bits 7..4 drive pin-2 ports 8..5
// - image byte 0 drives nothing here
// - byte 2 bit forces plain-input port into link mode
// - no cyclic data while overridden
// - byte 3 writes are ignored
// - process data lengths 1..32 each way
// - mapping mode leaves link data untouched
// - supply fault: group 0x0002, supply led off
// - supply fault leaves outputs alone
// - aux diagnostic 0x0103 only when enabled
// - aux fault adds per-port output diagnostics
// - sensor overload 0x01, driver hot 0x0113
// - faulted switching output off, then retried
// - switching fault reports port with 0x010A
// - error when commanded on, sensed off
// - error bit, red led, channel stays locked
// - edge window 0..255 ms, reset 80 ms
// - static error reported after filter delay
// - pin-2 error reports 0x05..0x08 with 0x0109
`timescale 1ns/1ps
module pod_port_diag
    import pod_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_img_wr,
    input wire logic [1:0] i_img_addr,
    input wire logic [7:0] i_img_data,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_aux_en,
    input wire logic [7:0] i_cfg_surv_ms,
    input wire logic i_len_wr,
    input wire logic [2:0] i_len_port,
    input wire logic [5:0] i_len_in,
    input wire logic [5:0] i_len_out,
    input wire logic [NPORT-1:0] i_port_plain_in,
    input wire pod_pins_t i_pins,
    output logic [NP2-1:0] o_pin2_drive,
    output logic [NPORT-1:0] o_link_mode,
    output logic [NPORT-1:0] o_pd_exchange,
    output logic [NPORT*6-1:0] o_pd_in_len,
    output logic [NPORT*6-1:0] o_pd_out_len,
    output logic o_sys_led,
    output logic o_aux_led_red,
    output logic [NP2-1:0] o_chan_led_red,
    output logic [NP2-1:0] o_pin2_err,
    output logic o_diag_valid,
    output pod_diag_t o_diag
);
    pod_pins_t sync1_reg;
    pod_pins_t pins_reg;
    logic [7:0] out_high_reg;
    logic [7:0] link_ovr_reg;
    logic aux_en_reg;
    logic [7:0] surv_reg;
    logic [31:0] ms_cnt_reg;
    logic ms_tick_reg;
    logic [NPORT-1:0] link_mode_reg;
    logic [NPORT-1:0] pd_ex_reg;
    logic [NPORT*6-1:0] in_len_reg;
    logic [NPORT*6-1:0] out_len_reg;
    logic sys_led_reg;
    logic aux_red_reg;
    wire [NP2-1:0] lock_reg;
    wire [NP2-1:0] drive_reg;
    logic [NCOND-1:0] rep_reg;
    logic [4:0] idx_reg;
    logic diag_valid_reg;
    pod_diag_t diag_reg;

    // two stages before any logic looks at a pin
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sync1_reg <= '0;
        end else begin
            sync1_reg <= i_pins;
        end
    end

    // only this stage reads the first one
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pins_reg <= '0;
        end else begin
            pins_reg <= sync1_reg;
        end
    end

    wire wr_high = i_img_wr && (i_img_addr == IMG_OUT_HIGH);
    wire wr_ovr = i_img_wr && (i_img_addr == IMG_LINK_OVR);
    wire ms_wrap = ms_cnt_reg == 32'(MS_TICK_CYCLES - 1);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            out_high_reg <= IMG_RESET;
        end else if (wr_high) begin
            out_high_reg <= i_img_data;
        end
    end

    // override byte kept apart so a drive write never touches it
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            link_ovr_reg <= IMG_RESET;
        end else if (wr_ovr) begin
            link_ovr_reg <= i_img_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            aux_en_reg <= 1'b0;
        end else if (i_cfg_wr) begin
            aux_en_reg <= i_cfg_aux_en;
        end
    end

    // a new window only applies from the next output edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            surv_reg <= SURV_RESET_MS;
        end else if (i_cfg_wr) begin
            surv_reg <= i_cfg_surv_ms;
        end
    end

    // millisecond enable for all timers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ms_cnt_reg <= '0;
        end else begin
            ms_cnt_reg <= ms_wrap ? '0 : ms_cnt_reg + 32'h1;
        end
    end

    // registered so every timer sees a clean one-cycle pulse
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ms_tick_reg <= 1'b0;
        end else begin
            ms_tick_reg <= ms_wrap;
        end
    end

    // override only acts on ports set up as plain inputs
    wire [NPORT-1:0] link_next = link_ovr_reg & i_port_plain_in;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            link_mode_reg <= '0;
        end else begin
            link_mode_reg <= link_next;
        end
    end

    // cyclic data stops in the same cycle the port switches over
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pd_ex_reg <= '1;
        end else begin
            pd_ex_reg <= ~link_next;
        end
    end

    // lengths clamped into range; independent of mapping mode
    wire in_short = i_len_in < PD_LEN_MIN;
    wire in_long = i_len_in > PD_LEN_MAX;
    wire out_short = i_len_out < PD_LEN_MIN;
    wire out_long = i_len_out > PD_LEN_MAX;
    wire [5:0] len_in_c = in_short ? PD_LEN_MIN : in_long ? PD_LEN_MAX : i_len_in;
    wire [5:0] len_out_c = out_short ? PD_LEN_MIN : out_long ? PD_LEN_MAX : i_len_out;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_len
            wire sel = i_len_wr && (i_len_port == 3'(p));
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    in_len_reg[p*6 +: 6] <= PD_LEN_RESET;
                    out_len_reg[p*6 +: 6] <= PD_LEN_RESET;
                end else if (sel) begin
                    in_len_reg[p*6 +: 6] <= len_in_c;
                    out_len_reg[p*6 +: 6] <= len_out_c;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            sys_led_reg <= 1'b0;
        end else begin
            sys_led_reg <= ~pins_reg.sys_bad;
        end
    end

    // red supply lamp shows the fault even with reporting off
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            aux_red_reg <= 1'b0;
        end else begin
            aux_red_reg <= pins_reg.aux_bad;
        end
    end

    // pin-2 channels: supervision, lock and retry
    genvar c;
    generate
        for (c = 0; c < NP2; c++) begin : g_p2
            logic [7:0] win_reg;
            logic [3:0] filt_reg;
            logic [7:0] retry_reg;
            logic cmd_prev_reg;
            logic eff_prev_reg;
            logic lock_bit_reg;
            logic drive_bit_reg;
            wire cmd = out_high_reg[P2_FIRST_BIT + c];
            wire swf = pins_reg.sw_fault[P2_FIRST_BIT + c];
            // supply state never gates the command
            wire eff = cmd && !lock_bit_reg && (retry_reg == 8'h00);
            wire edge_seen = eff ^ eff_prev_reg;
            wire raw = eff && (!pins_reg.p2_sense[c] || pins_reg.aux_bad);
            wire armed = raw && (win_reg == 8'h00) && !edge_seen;
            wire trip = armed && ms_tick_reg && (filt_reg == FILT_MS - 4'h1);
            always_ff @(posedge i_clk or posedge i_reset) begin
                if (i_reset) begin
                    win_reg <= 8'h00;
                    filt_reg <= 4'h0;
                    retry_reg <= 8'h00;
                    cmd_prev_reg <= 1'b0;
                    eff_prev_reg <= 1'b0;
                    lock_bit_reg <= 1'b0;
                    drive_bit_reg <= 1'b0;
                end else begin
                    cmd_prev_reg <= cmd;
                    eff_prev_reg <= eff;
                    drive_bit_reg <= eff;
                    if (edge_seen) begin
                        win_reg <= surv_reg;
                    end else if (ms_tick_reg && win_reg != 8'h00) begin
                        win_reg <= win_reg - 8'h01;
                    end
                    if (!armed) begin
                        filt_reg <= 4'h0;
                    end else if (ms_tick_reg) begin
                        filt_reg <= filt_reg + 4'h1;
                    end
                    // a set in the same cycle beats the unlock
                    if (trip) begin
                        lock_bit_reg <= 1'b1;
                    end else if (cmd_prev_reg && !cmd) begin
                        lock_bit_reg <= 1'b0;
                    end
                    if (swf && cmd && retry_reg == 8'h00) begin
                        retry_reg <= RETRY_MS;
                    end else if (ms_tick_reg && retry_reg != 8'h00) begin
                        retry_reg <= retry_reg - 8'h01;
                    end
                end
            end
            // one flop per bit; the vectors are only nets
            assign lock_reg[c] = lock_bit_reg;
            assign drive_reg[c] = drive_bit_reg;
        end
    endgenerate

    // condition vector scanned for changes
    wire [NCOND-1:0] cond = {
        lock_reg,
        pins_reg.sw_fault,
        pins_reg.drv_hot,
        pins_reg.sens_ovl,
        pins_reg.aux_bad && aux_en_reg,
        pins_reg.sys_bad
    };

    function automatic pod_diag_t diag_of(input logic [4:0] k, input logic on);
        pod_diag_t d;
        d.appear = on;
        d.channel = CH_GROUP;
        d.code = CODE_SYS;
        if (k == COND_AUX) begin
            d.code = CODE_AUX;
        end else if (k >= COND_P2) begin
            d.channel = 16'(k - COND_P2) + 16'(P2_FIRST_PORT);
            d.code = CODE_P2;
        end else if (k >= COND_SWF) begin
            d.channel = 16'(k - COND_SWF) + 16'h0001;
            d.code = CODE_SWF;
        end else if (k >= COND_HOT) begin
            d.channel = 16'(k - COND_HOT) + 16'h0001;
            d.code = CODE_HOT;
        end else if (k >= COND_SENS) begin
            d.channel = 16'(k - COND_SENS) + 16'h0001;
            d.code = CODE_SENS;
        end
        return d;
    endfunction

    wire cur = cond[idx_reg];
    wire changed = cur != rep_reg[idx_reg];

    // one event per change; latency up to one scan of all conditions
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            idx_reg <= COND_SYS;
            rep_reg <= '0;
            diag_valid_reg <= 1'b0;
            diag_reg <= '0;
        end else begin
            idx_reg <= (idx_reg == COND_LAST) ? COND_SYS : idx_reg + 5'h01;
            diag_valid_reg <= changed;
            if (changed) begin
                rep_reg[idx_reg] <= cur;
                diag_reg <= diag_of(idx_reg, cur);
            end
        end
    end

    assign o_pin2_drive = drive_reg;
    assign o_link_mode = link_mode_reg;
    assign o_pd_exchange = pd_ex_reg;
    assign o_pd_in_len = in_len_reg;
    assign o_pd_out_len = out_len_reg;
    assign o_sys_led = sys_led_reg;
    assign o_aux_led_red = aux_red_reg;
    assign o_chan_led_red = lock_reg;
    assign o_pin2_err = lock_reg;
    assign o_diag_valid = diag_valid_reg;
    assign o_diag = diag_reg;
endmodule

// ===== rtl/pod_pkg.sv
/*
 pod_pkg: constants and carrier types for the port output and
 diagnostics block. Assumes a single 200 MHz clock domain.
*/
package pod_pkg;
    localparam int NPORT = 8;
    localparam int NP2 = 4;
    localparam int P2_FIRST_BIT = 4;
    localparam int P2_FIRST_PORT = 5;
    localparam logic [1:0] IMG_OUT_LOW = 2'h0;
    localparam logic [1:0] IMG_OUT_HIGH = 2'h1;
    localparam logic [1:0] IMG_LINK_OVR = 2'h2;
    localparam logic [1:0] IMG_RSVD = 2'h3;
    localparam logic [7:0] IMG_RESET = 8'h00;
    localparam int CLK_HZ = 200_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam logic [7:0] SURV_RESET_MS = 8'h50;
    localparam logic [3:0] FILT_MS = 4'h8;
    localparam logic [7:0] RETRY_MS = 8'h64;
    localparam logic [5:0] PD_LEN_MIN = 6'h01;
    localparam logic [5:0] PD_LEN_MAX = 6'h20;
    localparam logic [5:0] PD_LEN_RESET = 6'h01;
    localparam logic [15:0] CH_GROUP = 16'h8000;
    localparam logic [15:0] CODE_SYS = 16'h0002;
    localparam logic [15:0] CODE_AUX = 16'h0103;
    localparam logic [15:0] CODE_SENS = 16'h0001;
    localparam logic [15:0] CODE_HOT = 16'h0113;
    localparam logic [15:0] CODE_SWF = 16'h010A;
    localparam logic [15:0] CODE_P2 = 16'h0109;
    localparam logic [4:0] COND_SYS = 5'h00;
    localparam logic [4:0] COND_AUX = 5'h01;
    localparam logic [4:0] COND_SENS = 5'h02;
    localparam logic [4:0] COND_HOT = 5'h0A;
    localparam logic [4:0] COND_SWF = 5'h12;
    localparam logic [4:0] COND_P2 = 5'h1A;
    localparam logic [4:0] COND_LAST = 5'h1D;
    localparam int NCOND = 30;

    typedef struct packed {
        logic [15:0] channel;
        logic [15:0] code;
        logic appear;
    } pod_diag_t;

    typedef struct packed {
        logic sys_bad;
        logic aux_bad;
        logic [NPORT-1:0] sens_ovl;
        logic [NPORT-1:0] drv_hot;
        logic [NPORT-1:0] sw_fault;
        logic [NP2-1:0] p2_sense;
    } pod_pins_t;
endpackage

// ===== tb/pod_port_diag_asserts.sv
/* pod_port_diag_asserts: port checks for pod_port_diag.
 Assumes one clock domain; bound below the module. */
`timescale 1ns/1ps
module pod_port_diag_asserts
    import pod_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_aux_en,
    input wire logic [NPORT-1:0] o_link_mode,
    input wire logic [NPORT-1:0] o_pd_exchange,
    input wire logic o_sys_led,
    input wire logic [NP2-1:0] o_pin2_drive,
    input wire logic [NP2-1:0] o_chan_led_red,
    input wire logic [NP2-1:0] o_pin2_err,
    input wire logic o_diag_valid,
    input wire pod_diag_t o_diag
);
    logic en_reg;
    wire ov = o_diag_valid;
    wire ev = ov && o_diag.appear;
    wire [15:0] cd = o_diag.code;
    wire [15:0] ch = o_diag.channel;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            en_reg <= 1'b0;
        end else if (i_cfg_wr) begin
            en_reg <= i_cfg_aux_en;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    AST_EXCH: assert property (o_pd_exchange == ~o_link_mode)
        else $error("exchange not inverse of link");
    AST_SYS: assert property (ev && cd == CODE_SYS |-> !o_sys_led)
        else $error("supply event, led lit");
    AST_GRP: assert property (ov && (cd == CODE_SYS || cd == CODE_AUX) |-> ch == CH_GROUP)
        else $error("group event off channel");
    // enable may drop in the cycle the event leaves
    AST_AUX: assert property (ev && cd == CODE_AUX |-> en_reg || $past(en_reg))
        else $error("aux event while disabled");
    AST_LOCK: assert property ((o_pin2_drive & $past(o_pin2_err)) == 4'h0)
        else $error("locked channel driven");
    AST_LED: assert property (o_chan_led_red == o_pin2_err &&
        (o_pin2_err & ~$past(o_pin2_err) & ~o_pin2_drive) == 4'h0)
        else $error("red led differs or error on undriven channel");
    AST_P2: assert property (ov && cd == CODE_P2 |->
        ch inside {[16'h0005:16'h0008]}) else $error("pin-2 event channel");
    AST_SENS: assert property (ov && (cd == CODE_SENS || cd == CODE_HOT) |->
        ch inside {[16'h0001:16'h0008]}) else $error("sensor event channel");
    AST_SWF: assert property (ov && cd == CODE_SWF |->
        ch inside {[16'h0001:16'h0008]}) else $error("switching event channel");
    cover property (ev && cd == CODE_P2);
    cover property (ev && cd == CODE_AUX);
    cover property (ev && cd == CODE_SWF);
endmodule
bind pod_port_diag pod_port_diag_asserts pod_port_diag_asserts_inst (.i_clk, .i_reset,
    .i_cfg_wr, .i_cfg_aux_en, .o_link_mode, .o_pd_exchange, .o_sys_led, .o_pin2_drive,
    .o_chan_led_red, .o_pin2_err, .o_diag_valid, .o_diag);

// ===== tb/pod_plc.sv
/* pod_plc: controller side, one-cycle write strobes.
 Assumes the block's clock; fields change 1 ns after an edge. */
`timescale 1ns/1ps
module pod_plc (
    input wire logic i_clk,
    output logic o_img_wr,
    output logic [1:0] o_img_addr,
    output logic [7:0] o_img_data,
    output logic o_cfg_wr,
    output logic o_cfg_aux_en,
    output logic [7:0] o_cfg_surv_ms,
    output logic o_len_wr,
    output logic [2:0] o_len_port,
    output logic [5:0] o_len_in,
    output logic [5:0] o_len_out
);
    initial begin
        {o_img_wr, o_img_addr, o_img_data, o_cfg_wr, o_cfg_aux_en, o_cfg_surv_ms} = '0;
        {o_len_wr, o_len_port, o_len_in, o_len_out} = '0;
    end
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask
    // data inverted on release so a stale byte is never reused
    task automatic put_img(input logic [1:0] a, input logic [7:0] d);
        step();
        {o_img_wr, o_img_addr, o_img_data} = {1'b1, a, d};
        step();
        {o_img_wr, o_img_data} = {1'b0, ~d};
    endtask
    task automatic put_cfg(input logic e, input logic [7:0] m);
        step();
        {o_cfg_wr, o_cfg_aux_en, o_cfg_surv_ms} = {1'b1, e, m};
        step();
        o_cfg_wr = 1'b0;
    endtask
    task automatic put_len(input logic [2:0] p, input logic [5:0] a, input logic [5:0] b);
        step();
        {o_len_wr, o_len_port, o_len_in, o_len_out} = {1'b1, p, a, b};
        step();
        o_len_wr = 1'b0;
    endtask
endmodule

// ===== tb/test_pod_port_diag.sv
/* test_pod_port_diag: bench for pod_port_diag.
 Assumes pod_plc as writer and the bound checker. */
`timescale 1ns/1ps
module test_pod_port_diag;
    import pod_pkg::*;
    localparam int TK = 10;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_img_wr, i_cfg_wr, i_cfg_aux_en, i_len_wr, o_sys_led, o_aux_led_red, o_diag_valid;
    logic [1:0] i_img_addr;
    logic [7:0] i_img_data, i_cfg_surv_ms, o_link_mode, o_pd_exchange;
    logic [7:0] i_port_plain_in = '0, sens = '0, hot = '0, swf = '0;
    logic [2:0] i_len_port;
    logic [5:0] i_len_in, i_len_out;
    logic [3:0] kill = '0, o_pin2_drive, o_chan_led_red, o_pin2_err;
    logic [47:0] o_pd_in_len, o_pd_out_len;
    logic sys_bad = 1'b0, aux_bad = 1'b0;
    pod_diag_t o_diag;
    pod_pins_t i_pins;
    int errors = 0, cmp_count = 0, aux_seen = 0, n;
    // sensed level follows the drive unless the channel is shorted
    assign i_pins = '{sys_bad, aux_bad, sens, hot, swf, o_pin2_drive & ~kill};
    pod_plc pod_plc_inst (.i_clk, .o_img_wr(i_img_wr), .o_img_addr(i_img_addr),
        .o_img_data(i_img_data), .o_cfg_wr(i_cfg_wr), .o_cfg_aux_en(i_cfg_aux_en),
        .o_cfg_surv_ms(i_cfg_surv_ms), .o_len_wr(i_len_wr), .o_len_port(i_len_port),
        .o_len_in(i_len_in), .o_len_out(i_len_out));
    pod_port_diag #(.MS_TICK_CYCLES(TK)) pod_port_diag_inst (.i_clk, .i_reset, .i_img_wr,
        .i_img_addr, .i_img_data, .i_cfg_wr, .i_cfg_aux_en, .i_cfg_surv_ms, .i_len_wr,
        .i_len_port, .i_len_in, .i_len_out, .i_port_plain_in, .i_pins, .o_pin2_drive,
        .o_link_mode, .o_pd_exchange, .o_pd_in_len, .o_pd_out_len, .o_sys_led,
        .o_aux_led_red, .o_chan_led_red, .o_pin2_err, .o_diag_valid, .o_diag);
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_diag(input logic [15:0] c, input logic [15:0] d, input logic a);
        n = 0;
        while (!(o_diag_valid === 1'b1 && o_diag === {c, d, a}) && n < 3000) begin
            tick(1);
            n++;
        end
        chk("diag wait", 48'h0, 48'(n >= 3000));
        if (n >= 3000) close_out();
    endtask
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_diag_valid === 1'b1 && o_diag.code === CODE_AUX) aux_seen++;
    end
    initial begin
        tick(5);
        i_reset = 1'b0;
        tick(4);
        chk("reset", {8{6'h01}}, o_pd_in_len);
        chk("reset", 48'h1FF, {o_sys_led, o_pd_exchange});
        pod_plc_inst.put_cfg(1'b0, 8'h0A);
        pod_plc_inst.put_img(IMG_OUT_LOW, 8'hFF);
        pod_plc_inst.put_img(IMG_RSVD, 8'hFF);
        pod_plc_inst.put_img(IMG_OUT_HIGH, 8'h0F);
        tick(4);
        chk("ignored", 48'h0, {o_link_mode, o_pin2_drive});
        pod_plc_inst.put_img(IMG_OUT_HIGH, 8'hA0);
        i_port_plain_in = 8'h0F;
        pod_plc_inst.put_img(IMG_LINK_OVR, 8'h3C);
        tick(4);
        chk("drive", 48'hA, o_pin2_drive);
        chk("link", 48'h0CF3, {o_link_mode, o_pd_exchange});
        pod_plc_inst.put_img(IMG_LINK_OVR, 8'h00);
        pod_plc_inst.put_len(3'h3, 6'h00, 6'h28);
        pod_plc_inst.put_len(3'h7, 6'h20, 6'h11);
        tick(2);
        chk("len", {6'h01, 6'h20, 6'h20, 6'h11}, {o_pd_in_len[23:18],
            o_pd_out_len[23:18], o_pd_in_len[47:42], o_pd_out_len[47:42]});
        sys_bad = 1'b1;
        wait_diag(CH_GROUP, CODE_SYS, 1'b1);
        chk("sys", 48'hA, {o_sys_led, o_pin2_drive});
        sys_bad = 1'b0;
        wait_diag(CH_GROUP, CODE_SYS, 1'b0);
        aux_bad = 1'b1;
        wait_diag(16'h0006, CODE_P2, 1'b1);
        chk("aux seen", 48'h0, aux_seen);
        pod_plc_inst.put_cfg(1'b1, 8'h0A);
        wait_diag(CH_GROUP, CODE_AUX, 1'b1);
        chk("aux led", 48'h1, o_aux_led_red);
        aux_bad = 1'b0;
        wait_diag(CH_GROUP, CODE_AUX, 1'b0);
        chk("aux led", 48'h0, o_aux_led_red);
        chk("lock", 48'hAA, {o_chan_led_red, o_pin2_err});
        pod_plc_inst.put_img(IMG_OUT_HIGH, 8'h00);
        tick(4);
        chk("unlock", 48'h0, o_pin2_err);
        kill = 4'h1;
        pod_plc_inst.put_img(IMG_OUT_HIGH, 8'h10);
        wait_diag(16'h0005, CODE_P2, 1'b1);
        chk("window", 48'h1, 48'(n >= 16 * TK && n <= 24 * TK));
        kill = 4'h0;
        tick(40);
        chk("held", 48'h10, {o_pin2_err, o_pin2_drive});
        pod_plc_inst.put_img(IMG_OUT_HIGH, 8'h00);
        wait_diag(16'h0005, CODE_P2, 1'b0);
        sens = 8'h04;
        wait_diag(16'h0003, CODE_SENS, 1'b1);
        hot = 8'h10;
        wait_diag(16'h0005, CODE_HOT, 1'b1);
        pod_plc_inst.put_img(IMG_OUT_HIGH, 8'h40);
        tick(30);
        swf = 8'h40;
        wait_diag(16'h0007, CODE_SWF, 1'b1);
        tick(2);
        chk("swf off", 48'h0, o_pin2_drive);
        swf = 8'h00;
        n = 0;
        while (o_pin2_drive !== 4'h4 && n < 1100) begin
            tick(1);
            n++;
        end
        chk("retry", 48'h1, 48'(n > 900 && n < 1100));
        close_out();
    end
endmodule
